// ---- shared/opfp_pkg.sv ----
// Constants, field layouts and types for the output protection block.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone bus.
package opfp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_STAT     = 8'h04;
   localparam logic [7:0] ADR_DELAY    = 8'h08;
   localparam logic [7:0] ADR_CMD      = 8'h0C;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

   ////////////////////////////////////////////////////////////////////////
   // Control word fields (low seven bits are also the saved setup)
   localparam int CTL_OUT_EN  = 0;
   localparam int CTL_FI_EN   = 1;
   localparam int CTL_OCP_EN  = 2;
   localparam int CTL_COMP    = 3;
   localparam int CTL_SRC_LSB = 4;
   localparam int CTL_INH_LSB = 8;
   localparam int CTL_PON     = 12;
   localparam int SETUP_W     = 7;

   // Command word bits, write only, self clearing
   localparam int CMD_CLEAR  = 0;
   localparam int CMD_RESET  = 1;
   localparam int CMD_RECALL = 2;
   localparam int CMD_SAVE   = 3;
   localparam int CMD_PROG   = 4;

   // Status word bits
   localparam int ST_OUT_ON  = 0;
   localparam int ST_FAULT   = 1;
   localparam int ST_CC_REC  = 2;
   localparam int ST_OCP     = 3;
   localparam int ST_INH_LOW = 4;
   localparam int ST_OV      = 5;
   localparam int ST_OT      = 6;
   localparam int ST_DLY_RUN = 7;

   // Interrupt status and mask bits
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_CC    = 1;
   localparam int IRQ_INH   = 2;
   localparam int IRQ_W     = 3;

   // Status byte bit positions of the summary sources
   localparam int SB_QUESTIONABLE_SUMMARY = 3;
   localparam int SB_ESB  = 5;
   localparam int SB_RQS  = 6;
   localparam int SB_OPERATION_SUMMARY = 7;

   ////////////////////////////////////////////////////////////////////////
   // Protection delay, counted in milliseconds
   localparam int          DELAY_W        = 31;
   localparam logic [30:0] DELAY_RST_MS   = 31'h0000_0050;
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          DELAY_UNIT_NS  = 1_000_000;
   localparam int          TICK_CYC       = DELAY_UNIT_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      SRC_OFF  = 3'h0,
      SRC_QUESTIONABLE_SUMMARY = 3'h1,
      SRC_OPERATION_SUMMARY = 3'h2,
      SRC_ESB  = 3'h3,
      SRC_RQS  = 3'h4
   } opfp_src_type;

   typedef enum logic [1:0] {
      INH_OFF   = 2'h0,
      INH_LATCH = 2'h1,
      INH_LIVE  = 2'h2
   } opfp_inh_type;

endpackage

// ---- rtl/opfp_output_protect.sv ----
// Output enable, fault latch, inhibit and fault indicator control.
// Assumes status inputs from analog comparators are asynchronous and the
// status byte comes from logic on clk_i; storage is kept outside.
module opfp_output_protect #(
   parameter int TICK_CYCLES = opfp_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // Analog status, asynchronous
   input  wire logic                          overvoltage_i,
   input  wire logic                          overtemp_i,
   input  wire logic                          constant_current_state_i,
   input  wire logic                          inhibit_in_n_i,
   // Status subsystem, same clock
   input  wire logic [7:0]                    status_byte_i,
   input  wire logic                          program_event_i,
   // Stored settings
   input  wire logic                          nv_power_on_state_i,
   input  wire logic [1:0]                    nv_inhibit_mode_i,
   input  wire logic [opfp_pkg::SETUP_W-1:0]  slot0_setup_i,
   input  wire logic [opfp_pkg::DELAY_W-1:0]  slot0_delay_i,
   output logic                               nv_write_o,
   output logic                               nv_power_on_state_o,
   output logic      [1:0]                    nv_inhibit_mode_o,
   output logic                               slot0_save_o,
   output logic      [opfp_pkg::SETUP_W-1:0]  slot0_setup_o,
   output logic      [opfp_pkg::DELAY_W-1:0]  slot0_delay_o,
   // Output stage and pins
   output logic                               output_enable_o,
   output logic                               compensation_high_o,
   output logic                               constant_current_state_o,
   output logic                               fault_indicator_out_o,
   output logic                               irq_o
);
   import opfp_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   if (TICK_CYCLES < 1) begin : g_chk
      $error("TICK_CYCLES must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0]         ov_s;
      logic [1:0]         ot_s;
      logic [1:0]         cc_s;
      logic [1:0]         inh_s;
      logic               inh_d;
      logic               init;
      logic               out_en;
      logic               saved_en;
      logic               fi_en;
      logic               ocp_en;
      logic               comp;
      opfp_src_type       src;
      opfp_inh_type       inh_mode;
      logic               pon;
      logic [DELAY_W-1:0] delay;
      logic [DELAY_W-1:0] dly_cnt;
      logic [TW-1:0]      tick;
      logic               dly_done;
      logic               cc_rec;
      logic               fault;
      logic               ocp_flag;
      logic [IRQ_W-1:0]   irq_st;
      logic [IRQ_W-1:0]   irq_mk;
      logic               ack;
      logic [31:0]        dat;
      logic               oe;
      logic               fio;
      logic               save;
      logic               nv_wr;
   } opfp_state_type;

   opfp_state_type s_r;
   opfp_state_type s_nxt;
   // Control word view shared by the saved setup output
   logic [31:0]    ctrl_now;

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] ctrl_word(input opfp_state_type s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CTL_OUT_EN] = s.out_en;
      w[CTL_FI_EN]  = s.fi_en;
      w[CTL_OCP_EN] = s.ocp_en;
      w[CTL_COMP]   = s.comp;
      w[CTL_SRC_LSB +: 3] = s.src;
      w[CTL_INH_LSB +: 2] = s.inh_mode;
      w[CTL_PON]    = s.pon;
      return w;
   endfunction

   // Unknown source codes behave as OFF
   function automatic logic pick_src(input opfp_src_type src,
                                     input logic [7:0]   sb);
      logic r;
      r = 1'b0;
      case (src)
         SRC_QUESTIONABLE_SUMMARY: r = sb[SB_QUESTIONABLE_SUMMARY];
         SRC_OPERATION_SUMMARY: r = sb[SB_OPERATION_SUMMARY];
         SRC_ESB:  r = sb[SB_ESB];
         SRC_RQS:  r = sb[SB_RQS];
         default:  r = 1'b0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0]      wdat;
      logic [31:0]      cw;
      logic [DELAY_W:0] dw;
      logic [4:0]       cmd;
      logic             wr;
      logic             ov;
      logic             ot;
      logic             cc;
      logic             inh_low;
      logic             prog;
      logic             ocp_cause;
      logic             inh_cause;
      logic             cause;
      logic             live_blk;
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      wdat      = 32'h0000_0000;
      cw        = 32'h0000_0000;
      dw        = '0;
      cmd       = 5'h00;
      ev        = '0;
      clr       = '0;
      prog      = 1'b0;
      wr        = 1'b0;
      ov        = 1'b0;
      ot        = 1'b0;
      cc        = 1'b0;
      inh_low   = 1'b0;
      ocp_cause = 1'b0;
      inh_cause = 1'b0;
      cause     = 1'b0;
      live_blk  = 1'b0;
      s_nxt     = s_r;
      s_nxt.save  = 1'b0;
      s_nxt.nv_wr = 1'b0;
      s_nxt.dat   = 32'h0000_0000;
      // Single-cycle ack, dropped the cycle after it is given
      s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = s_nxt.ack & wb_we_i;
      // Two-stage synchronisers; only stage two feeds the logic
      s_nxt.ov_s  = {s_r.ov_s[0], overvoltage_i};
      s_nxt.ot_s  = {s_r.ot_s[0], overtemp_i};
      s_nxt.cc_s  = {s_r.cc_s[0], constant_current_state_i};
      s_nxt.inh_s = {s_r.inh_s[0], inhibit_in_n_i};
      s_nxt.inh_d = s_r.inh_s[1];
      ov      = s_r.ov_s[1];
      ot      = s_r.ot_s[1];
      cc      = s_r.cc_s[1];
      inh_low = ~s_r.inh_s[1];

      // Power-on load from stored settings, one cycle after reset
      if (s_r.init) begin
         s_nxt.init     = 1'b0;
         s_nxt.pon      = nv_power_on_state_i;
         s_nxt.inh_mode = opfp_inh_type'(nv_inhibit_mode_i);
         if (nv_power_on_state_i) begin
            s_nxt.out_en = slot0_setup_i[CTL_OUT_EN];
            s_nxt.fi_en  = slot0_setup_i[CTL_FI_EN];
            s_nxt.ocp_en = slot0_setup_i[CTL_OCP_EN];
            s_nxt.comp   = slot0_setup_i[CTL_COMP];
            s_nxt.src    = opfp_src_type'(slot0_setup_i[CTL_SRC_LSB +: 3]);
            s_nxt.delay  = slot0_delay_i;
            prog         = 1'b1;
         end
      end

      if (wr) begin
         case (wb_adr_i)
            ADR_CTRL: begin
               cw = wb_merge(ctrl_word(s_r), wb_dat_i, wb_sel_i);
               s_nxt.out_en = cw[CTL_OUT_EN];
               s_nxt.fi_en  = cw[CTL_FI_EN];
               s_nxt.ocp_en = cw[CTL_OCP_EN];
               s_nxt.comp   = cw[CTL_COMP];
               s_nxt.src    = opfp_src_type'(cw[CTL_SRC_LSB +: 3]);
               s_nxt.inh_mode = opfp_inh_type'(cw[CTL_INH_LSB +: 2]);
               s_nxt.pon    = cw[CTL_PON];
               // Stored copy follows any change of stored fields
               s_nxt.nv_wr  = (s_nxt.inh_mode != s_r.inh_mode) |
                              (s_nxt.pon != s_r.pon);
               prog = cw[CTL_OUT_EN] & ~s_r.out_en;
            end
            ADR_DELAY: begin
               cw = wb_merge({1'b0, s_r.delay}, wb_dat_i, wb_sel_i);
               s_nxt.delay = cw[DELAY_W-1:0];
            end
            ADR_CMD: begin
               wdat = wb_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
               cmd  = wdat[4:0];
            end
            ADR_IRQ_STAT: begin
               wdat = wb_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
               clr  = wdat[IRQ_W-1:0];
            end
            ADR_IRQ_MASK: begin
               wdat = wb_merge({29'h0, s_r.irq_mk}, wb_dat_i, wb_sel_i);
               s_nxt.irq_mk = wdat[IRQ_W-1:0];
            end
            default: ;
         endcase
      end

      // Command reset leaves the stored fields alone
      if (cmd[CMD_RESET]) begin
         s_nxt.out_en = 1'b0;
         s_nxt.fi_en  = 1'b0;
         s_nxt.ocp_en = 1'b0;
         s_nxt.comp   = 1'b0;
         s_nxt.src    = SRC_OFF;
         s_nxt.delay  = DELAY_RST_MS;
         prog         = 1'b1;
      end
      if (cmd[CMD_RECALL]) begin
         s_nxt.out_en = slot0_setup_i[CTL_OUT_EN];
         s_nxt.fi_en  = slot0_setup_i[CTL_FI_EN];
         s_nxt.ocp_en = slot0_setup_i[CTL_OCP_EN];
         s_nxt.comp   = slot0_setup_i[CTL_COMP];
         s_nxt.src    = opfp_src_type'(slot0_setup_i[CTL_SRC_LSB +: 3]);
         s_nxt.delay  = slot0_delay_i;
         prog         = 1'b1;
      end
      s_nxt.save = cmd[CMD_SAVE];
      prog = prog | cmd[CMD_PROG] | program_event_i;

      // Delay timer: restart on every programming event
      if (prog) begin
         s_nxt.tick     = '0;
         s_nxt.dly_cnt  = s_nxt.delay;
         s_nxt.dly_done = (s_nxt.delay == '0);
      end else if (!s_r.dly_done) begin
         if (s_r.tick == TW'(TICK_CYCLES - 1)) begin
            s_nxt.tick = '0;
            dw = {1'b0, s_r.dly_cnt} - 1'b1;
            s_nxt.dly_cnt = dw[DELAY_W-1:0];
            s_nxt.dly_done = (s_r.dly_cnt <= 31'h0000_0001);
         end else begin
            s_nxt.tick = s_r.tick + 1'b1;
         end
      end
      // Short constant-current spells inside the delay never register
      s_nxt.cc_rec = cc & s_r.dly_done & ~prog;

      // Fault latch; a set in the clear cycle wins
      ocp_cause = s_r.ocp_en & s_r.cc_rec;
      inh_cause = (s_r.inh_mode == INH_LATCH) & inh_low;
      cause = ov | ot | ocp_cause | inh_cause;
      if (cmd[CMD_CLEAR] && s_r.fault && !cause) begin
         s_nxt.fault    = 1'b0;
         s_nxt.out_en   = s_r.saved_en;
         s_nxt.ocp_flag = 1'b0;
      end
      if (cause && !s_r.fault) begin
         s_nxt.fault    = 1'b1;
         s_nxt.saved_en = s_nxt.out_en;
         s_nxt.out_en   = 1'b0;
         ev[IRQ_FAULT]  = 1'b1;
      end
      if (ocp_cause) begin
         s_nxt.ocp_flag = 1'b1;
      end

      // Live mode gates without latching; OFF mode never looks
      live_blk = (s_r.inh_mode == INH_LIVE) & inh_low;
      s_nxt.oe = s_nxt.out_en & ~s_nxt.fault & ~live_blk;
      s_nxt.fio = s_nxt.fi_en & pick_src(s_nxt.src, status_byte_i);

      ev[IRQ_CC]  = s_nxt.cc_rec & ~s_r.cc_rec;
      ev[IRQ_INH] = inh_low & s_r.inh_d &
                    (s_r.inh_mode != INH_OFF);
      s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;

      if (s_nxt.ack && !wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL:  s_nxt.dat = ctrl_word(s_r);
            ADR_STAT: begin
               s_nxt.dat[ST_OUT_ON]  = s_r.oe;
               s_nxt.dat[ST_FAULT]   = s_r.fault;
               s_nxt.dat[ST_CC_REC]  = s_r.cc_rec;
               s_nxt.dat[ST_OCP]     = s_r.ocp_flag;
               s_nxt.dat[ST_INH_LOW] = inh_low;
               s_nxt.dat[ST_OV]      = ov;
               s_nxt.dat[ST_OT]      = ot;
               s_nxt.dat[ST_DLY_RUN] = ~s_r.dly_done;
            end
            ADR_DELAY:    s_nxt.dat = {1'b0, s_r.delay};
            ADR_IRQ_STAT: s_nxt.dat = {29'h0, s_r.irq_st};
            ADR_IRQ_MASK: s_nxt.dat = {29'h0, s_r.irq_mk};
            default:      s_nxt.dat = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r          <= '0;
         s_r.init     <= 1'b1;
         s_r.src      <= SRC_OFF;
         s_r.inh_mode <= INH_OFF;
         s_r.delay    <= DELAY_RST_MS;
         s_r.dly_cnt  <= DELAY_RST_MS;
         s_r.inh_s    <= 2'h3;
         s_r.inh_d    <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign wb_dat_o                 = s_r.dat;
   assign wb_ack_o                 = s_r.ack;
   assign nv_write_o               = s_r.nv_wr;
   assign nv_power_on_state_o      = s_r.pon;
   assign nv_inhibit_mode_o        = s_r.inh_mode;
   assign slot0_save_o             = s_r.save;
   assign ctrl_now                 = ctrl_word(s_r);
   assign slot0_setup_o            = ctrl_now[SETUP_W-1:0];
   assign slot0_delay_o            = s_r.delay;
   assign output_enable_o          = s_r.oe;
   assign compensation_high_o      = s_r.comp;
   assign constant_current_state_o = s_r.cc_rec;
   assign fault_indicator_out_o    = s_r.fio;
   assign irq_o                    = |(s_r.irq_st & s_r.irq_mk);

endmodule

// ---- testbench/opfp_ext_tester.sv ----
// Fixture on the inhibit and fault indicator lines.
// Inhibit idles high, driven high by the fixture while no inhibit is requested.
module opfp_ext_tester (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Bench request, observed line
   input  wire logic       inhibit_req_i,
   input  wire logic       fault_indicator_out_i,
   // Toward device and bench
   output logic            inhibit_in_n_o,
   output logic      [7:0] fault_rises_o
);
   logic fi_last_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inhibit_in_n_o <= 1'h1;
         fault_rises_o  <= 8'h00;
         fi_last_r      <= 1'h0;
      end else begin
         // Released line goes back high
         inhibit_in_n_o <= !inhibit_req_i;
         fi_last_r      <= fault_indicator_out_i;
         if (fault_indicator_out_i && !fi_last_r) begin
            fault_rises_o <= fault_rises_o + 8'h01;
         end
      end
   end
endmodule

// ---- testbench/opfp_output_protect_checker.sv ----
// Port checks on the output protection block.
// Bound to the block; sees its ports only.
module opfp_output_protect_checker #(
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Pins and outputs
   input wire logic        overvoltage_i,
   input wire logic        overtemp_i,
   input wire logic        constant_current_state_i,
   input wire logic        constant_current_state_o,
   input wire logic        output_enable_o,
   input wire logic        fault_indicator_out_o,
   input wire logic        nv_write_o,
   input wire logic        slot0_save_o
);
   import opfp_pkg::*;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Long enough to cover the two-flop synchroniser
   sequence s_cause_held;
      (overvoltage_i || overtemp_i) [*5];
   endsequence
   sequence s_cc_gone;
      !constant_current_state_i [*4];
   endsequence

   ////////////////////////////////////////////////////////////////////////
   a_ack_answer: assert property (s_req |=> wb_ack_o)
      else $error("No ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack longer than one cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("Read data outside ack");
   a_fault_trip: assert property (s_cause_held |=> !output_enable_o)
      else $error("Output on during fault cause");
   a_cc_release: assert property (
      s_cc_gone |=> !constant_current_state_o)
      else $error("Constant current kept after input low");
   a_nv_pulse: assert property (nv_write_o |=> !nv_write_o)
      else $error("Stored write strobe too long");
   a_save_pulse: assert property (slot0_save_o |=> !slot0_save_o)
      else $error("Slot save strobe too long");
   a_reset_quiet: assert property ($fell(rst_i) |->
      !output_enable_o && !fault_indicator_out_o)
      else $error("Outputs active after reset");
endmodule

bind opfp_output_protect opfp_output_protect_checker #(
   .TICK_CYCLES(TICK_CYCLES)
) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .overvoltage_i(overvoltage_i),
   .overtemp_i(overtemp_i),
   .constant_current_state_i(constant_current_state_i),
   .constant_current_state_o(constant_current_state_o),
   .output_enable_o(output_enable_o),
   .fault_indicator_out_o(fault_indicator_out_o),
   .nv_write_o(nv_write_o), .slot0_save_o(slot0_save_o)
);

// ---- testbench/tb_top.sv ----
// Bench for the output protection block over Wishbone.
// TICK_CYCLES is 4: one delay unit is four clocks.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import opfp_pkg::*;
   `define CHK(n, e, g) chk(n, 32'(e), 32'(g))

   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [7:0]  adr = 8'h00, sb = 8'h00, rises;
   logic [31:0] dat = 32'h0, q, rdat;
   logic        ov = 1'h0, ot = 1'h0, cc = 1'h0, pe = 1'h0, pon = 1'h0;
   logic        inh_req = 1'h0;
   logic [1:0]  nvm = 2'h0, nvmo;
   logic [6:0]  s0 = 7'h00, s0o;
   logic [30:0] s0d;
   logic        ack, inh_n, nvw, nvp, sv, oe, comp, cco, fio, irq;
   int          fails = 0, cmp_count = 0;
   int          bt [4] = '{SB_QUESTIONABLE_SUMMARY, SB_OPERATION_SUMMARY, SB_ESB, SB_RQS};

   always #2.5 clk_i = ~clk_i;

   opfp_output_protect #(.TICK_CYCLES(4)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .overvoltage_i(ov),
      .overtemp_i(ot), .constant_current_state_i(cc),
      .inhibit_in_n_i(inh_n), .status_byte_i(sb), .program_event_i(pe),
      .nv_power_on_state_i(pon), .nv_inhibit_mode_i(nvm),
      .slot0_setup_i(s0), .slot0_delay_i(31'h3), .nv_write_o(nvw),
      .nv_power_on_state_o(nvp), .nv_inhibit_mode_o(nvmo),
      .slot0_save_o(sv), .slot0_setup_o(s0o), .slot0_delay_o(s0d),
      .output_enable_o(oe), .compensation_high_o(comp),
      .constant_current_state_o(cco), .fault_indicator_out_o(fio),
      .irq_o(irq));

   opfp_ext_tester ext (.clk_i(clk_i), .rst_i(rst_i),
      .inhibit_req_i(inh_req), .fault_indicator_out_i(fio),
      .inhibit_in_n_o(inh_n), .fault_rises_o(rises));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Held until ack is sampled; no fixed latency assumed
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= wr;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'h1 && n < 20);
      `CHK("ack", 1'h1, ack);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask

   task automatic do_rst();
      rst_i <= 1'h1;
      w(12);
      rst_i <= 1'h0;
   endtask

   task automatic clear_fault();
      bus(1'h1, ADR_CMD, 32'h1);
      w(2);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      w(20000);
      fails++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_rst();
      bus(1'h0, ADR_DELAY, 32'h0);
      `CHK("delay rst", DELAY_RST_MS, q);
      bus(1'h0, 8'h18, 32'h0);
      `CHK("unmapped", 32'h0, q);
      bus(1'h1, ADR_CTRL, 32'h9);
      w(2);
      `CHK("out on", 1'h1, oe);
      bus(1'h0, ADR_CTRL, 32'h0);
      `CHK("ctrl rb", 32'h9, q);
      `CHK("comp", 1'h1, comp);
      for (int s = 1; s <= 4; s++) begin
         bus(1'h1, ADR_CTRL, 32'(2 + 16 * s));
         sb <= 8'h1 << bt[s - 1];
         w(3);
         `CHK("fi set", 1'h1, fio);
         sb <= ~(8'h1 << bt[s - 1]);
         w(3);
         `CHK("fi clr", 1'h0, fio);
      end
      `CHK("fi rises", 8'h4, rises);
      bus(1'h1, ADR_CTRL, 32'h2);
      sb <= 8'hFF;
      w(3);
      `CHK("fi off", 1'h0, fio);
      bus(1'h1, ADR_CMD, 32'h2);
      bus(1'h0, ADR_CTRL, 32'h0);
      `CHK("cmd rst", 32'h0, q);
      `CHK("out off", 1'h0, oe);
      // Overvoltage acts while the delay still runs
      bus(1'h1, ADR_CTRL, 32'h1);
      pe <= 1'h1;
      w(1);
      pe <= 1'h0;
      ov <= 1'h1;
      w(6);
      `CHK("ov trip", 1'h0, oe);
      `CHK("irq mask", 1'h0, irq);
      bus(1'h1, ADR_IRQ_MASK, 32'h1);
      `CHK("irq on", 1'h1, irq);
      clear_fault();
      `CHK("clr refused", 1'h0, oe);
      bus(1'h0, ADR_STAT, 32'h0);
      `CHK("stat ov", 32'h22, q & 32'h22);
      ov <= 1'h0;
      ot <= 1'h1;
      w(6);
      ot <= 1'h0;
      w(4);
      clear_fault();
      `CHK("restored", 1'h1, oe);
      bus(1'h1, ADR_IRQ_STAT, 32'h1);
      `CHK("irq w1c", 1'h0, irq);
      bus(1'h1, ADR_CTRL, 32'h101);
      `CHK("nv write", 1'h1, nvw);
      `CHK("nv mode", 2'h1, nvmo);
      inh_req <= 1'h1;
      w(6);
      `CHK("latch off", 1'h0, oe);
      inh_req <= 1'h0;
      w(6);
      `CHK("latch held", 1'h0, oe);
      clear_fault();
      `CHK("latch clr", 1'h1, oe);
      for (int m = 0; m < 3; m += 2) begin
         bus(1'h1, ADR_CTRL, 32'(1 + 256 * m));
         inh_req <= 1'h1;
         w(6);
         `CHK("inh low", m == 0, oe);
         inh_req <= 1'h0;
         w(6);
         `CHK("inh high", 1'h1, oe);
      end
      // Delay of 2 units is 8 clocks here
      bus(1'h1, ADR_DELAY, 32'h2);
      bus(1'h1, ADR_CTRL, 32'h5);
      bus(1'h1, ADR_CMD, 32'h10);
      cc <= 1'h1;
      w(4);
      `CHK("cc held", 1'h0, cco);
      `CHK("ocp held", 1'h1, oe);
      w(12);
      `CHK("cc rec", 1'h1, cco);
      `CHK("ocp trip", 1'h0, oe);
      bus(1'h0, ADR_STAT, 32'h0);
      `CHK("stat ocp", 32'hE, q & 32'hE);
      cc <= 1'h0;
      w(5);
      clear_fault();
      `CHK("ocp clr", 1'h1, oe);
      bus(1'h1, ADR_CMD, 32'h10);
      cc <= 1'h1;
      w(2);
      cc <= 1'h0;
      w(14);
      `CHK("short cc", 1'h0, cco);
      `CHK("no trip", 1'h1, oe);
      bus(1'h1, ADR_CMD, 32'h8);
      `CHK("slot save", 7'h05, s0o);
      `CHK("save strobe", 1'h1, sv);
      `CHK("save delay", 31'h2, s0d);
      pon <= 1'h1;
      nvm <= 2'h2;
      s0 <= 7'h09;
      do_rst();
      w(3);
      `CHK("pon out", 1'h1, oe);
      bus(1'h0, ADR_CTRL, 32'h0);
      `CHK("pon ctrl", 32'h1209, q);
      `CHK("pon kept", 1'h1, nvp);
      bus(1'h0, ADR_DELAY, 32'h0);
      `CHK("pon delay", 32'h3, q);
      bus(1'h1, ADR_CMD, 32'h2);
      bus(1'h1, ADR_CMD, 32'h4);
      bus(1'h0, ADR_CTRL, 32'h0);
      `CHK("recall ctrl", 32'h1209, q);
      `CHK("recall out", 1'h1, oe);
      print_verdict();
   end
endmodule
